// ==== hdl/scan_params.svh ====
// Offsets, field positions, reset values and timing for the scan sequencer.
// Assumes inclusion by the sequencer module and the testbench only.
`ifndef SCAN_PARAMS_SVH
`define SCAN_PARAMS_SVH
// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_SCAN_AVG 8'h08
`define ADDR_FORCE 8'h0C
`define ADDR_RETAIN 8'h10
`define ADDR_LOOPS 8'h14
`define ADDR_SCAN_CNT 8'h18
`define ADDR_OVR_BASE 8'h20
`define ADDR_IMG_BASE 8'h40
`define ADDR_VMEM_BASE 8'h60
`define ADDR_RUNG_BASE 8'h80
// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define CTRL_REM_RUN 0
`define CTRL_REM_PROG 1
`define CTRL_EDIT 2
`define CTRL_COMMIT 3
`define CTRL_BAD_PROG 4
`define CTRL_NF_CLR 5
// ----------------------------------------------------------------------
// Rung fields
// ----------------------------------------------------------------------
`define RUNG_INV 8
`define RUNG_IMM 9
`define RUNG_END 18
// ----------------------------------------------------------------------
// Image words and reset values
// ----------------------------------------------------------------------
`define IMG_X 3'h0
`define IMG_XR 3'h1
`define IMG_Y 3'h2
`define IMG_SP 3'h7
`define RETAIN_RESET 8'h28
`define LOOPS_RESET 4'h0
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define RTC_TICK_MS 1000
`define RTC_TICK_CYCLES (`RTC_TICK_MS * 1000000 / `CLK_PERIOD_NS)
`endif

// ==== hdl/scan_pkg.sv ====
// Types shared by the scan sequencer.
// Assumes nothing beyond the parameter header.
package scan_pkg;
  // Scan segments in their cyclic order
  typedef enum logic [3:0] {
    ST_INIT, ST_RD_IN, ST_RD_SPEC, ST_SERVICE, ST_BUS,
    ST_CLOCK, ST_SOLVE, ST_LOOPS, ST_WR_OUT
  } seg_type;
  // Front switch positions
  typedef enum logic [1:0] {
    SW_PROG, SW_RUN, SW_REMOTE, SW_RSVD
  } switch_type;
endpackage : scan_pkg

// ==== hdl/scan_sequencer.sv ====
// Scan-cycle sequencer of a programmable controller CPU, AXI4-Lite registers.
// Assumes pins from outside the aclk domain; specialty bus requests on aclk.
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "scan_params.svh"
module scan_sequencer #(
  parameter int RTC_TICK_CYCLES = `RTC_TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] in_pins,
  input wire logic [15:0] specialty_in,
  input wire logic [15:0] remote_in,
  input wire logic [1:0] mode_switch,
  input wire logic fatal_error,
  input wire logic nonfatal_error,
  input wire logic xfer_req,
  input wire logic xfer_write,
  input wire logic [2:0] xfer_addr,
  input wire logic [31:0] xfer_wdata,
  output logic xfer_ack,
  output logic [31:0] xfer_rdata,
  output logic [31:0] out_pins,
  output logic [31:0] remote_out,
  output logic run_mode
);
  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [67:0] sync1_reg, sync2_reg;
  // Two stages; only the second stage is read by logic
  always_ff @(posedge aclk) begin
    sync1_reg <= {in_pins, specialty_in, remote_in, mode_switch, fatal_error, nonfatal_error};
    sync2_reg <= sync1_reg;
  end
  logic [31:0] in_s;
  logic [15:0] spec_s, rem_s;
  logic [1:0] sw_s;
  logic fatal_s, nonfatal_s;
  assign {in_s, spec_s, rem_s, sw_s, fatal_s, nonfatal_s} = sync2_reg;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Image, data and program arrays carry no reset so retentive words survive a reset; override masks do reset
  logic [31:0] img_mem [8];
  logic [31:0] vmem [8];
  logic [18:0] rung_mem [16];
  logic [31:0] ovr_reg [8];
  logic [31:0] force_reg;
  logic force_pend_reg;
  logic [7:0] retain_reg;
  logic [3:0] loops_reg;
  logic edit_reg, rem_run_reg, fatal_reg, run_reg;
  logic [7:0] nf_count_reg;
  logic [31:0] scan_avg_reg, scan_cnt_reg, scan_len_reg, rtc_reg, tick_reg;
  scan_pkg::seg_type seg_reg;
  logic [3:0] idx_reg;

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  logic wr_go, rd_go;
  logic [7:0] wa, ra;
  logic [31:0] wd;
  assign wa = s_axi_awaddr[7:0];
  assign ra = s_axi_araddr[7:0];
  // Address and data taken together; one write outstanding at a time
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go = s_axi_arvalid && !s_axi_rvalid;
  // Byte lanes merge into the old value for override and vmem words; other writes merge into zero
  function automatic logic [31:0] merge(input logic [31:0] old);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s_axi_wstrb[b]) begin
        r[b*8 +: 8] = s_axi_wdata[b*8 +: 8];
      end
    end
    return r;
  endfunction
  always_comb wd = merge(32'h0000_0000);
  logic wr_ctrl, wr_force, wr_ovr, wr_rung, wr_vmem, wr_known;
  assign wr_ctrl = wr_go && wa == `ADDR_CTRL;
  assign wr_force = wr_go && wa == `ADDR_FORCE;
  assign wr_ovr = wr_go && wa[7:5] == 3'h1;
  assign wr_vmem = wr_go && wa[7:5] == 3'h3;
  assign wr_rung = wr_go && wa[7:6] == 2'h2;
  assign wr_known = wr_ctrl || wr_force || wr_ovr || wr_rung || wr_vmem
    || wa == `ADDR_RETAIN || wa == `ADDR_LOOPS;
  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // Read data mux, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      if (ra[7:6] == 2'h2) s_axi_rdata <= {13'h0000, rung_mem[ra[5:2]]};
      else if (ra[7:5] == 3'h1) s_axi_rdata <= ovr_reg[ra[4:2]];
      else if (ra[7:5] == 3'h2) s_axi_rdata <= img_mem[ra[4:2]];
      else if (ra[7:5] == 3'h3) s_axi_rdata <= vmem[ra[4:2]];
      else begin
        case (ra)
          `ADDR_CTRL: s_axi_rdata <= {29'h0000_0000, edit_reg, 1'b0, rem_run_reg};
          `ADDR_STATUS: s_axi_rdata <= {nf_count_reg, 18'h0_0000, sw_s,
              force_pend_reg, fatal_reg, nonfatal_s, run_reg};
          `ADDR_SCAN_AVG: s_axi_rdata <= scan_avg_reg;
          `ADDR_FORCE: s_axi_rdata <= force_reg;
          `ADDR_RETAIN: s_axi_rdata <= {24'h00_0000, retain_reg};
          `ADDR_LOOPS: s_axi_rdata <= {28'h000_0000, loops_reg};
          `ADDR_SCAN_CNT: s_axi_rdata <= scan_cnt_reg;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      retain_reg <= `RETAIN_RESET;
      loops_reg <= `LOOPS_RESET;
    end else begin
      if (wr_go && wa == `ADDR_RETAIN) retain_reg <= wd[7:0];
      if (wr_go && wa == `ADDR_LOOPS) loops_reg <= wd[3:0];
    end
  end
  // Override masks, one word per image area
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 8; i++) ovr_reg[i] <= 32'h0000_0000;
    end else if (wr_ovr) begin
      ovr_reg[wa[4:2]] <= merge(ovr_reg[wa[4:2]]);
    end
  end
  // Program store; edits land at once, even in run
  always_ff @(posedge aclk) begin
    if (wr_rung) rung_mem[wa[5:2]] <= wd[18:0];
  end

  // ----------------------------------------------------------------------
  // Mode control
  // ----------------------------------------------------------------------
  logic bad_commit, want_run, sw_prog, rem_prog_cmd;
  assign bad_commit = wr_ctrl && wd[`CTRL_COMMIT] && wd[`CTRL_BAD_PROG];
  assign rem_prog_cmd = wr_ctrl && wd[`CTRL_REM_PROG];
  // Remote commands count only in the remote position
  assign want_run = sw_s == scan_pkg::SW_RUN
    || (sw_s == scan_pkg::SW_REMOTE && rem_run_reg);
  assign sw_prog = sw_s == scan_pkg::SW_PROG;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rem_run_reg <= 1'b0;
      edit_reg <= 1'b0;
    end else begin
      if (wr_ctrl && sw_s == scan_pkg::SW_REMOTE) begin
        rem_run_reg <= wd[`CTRL_REM_RUN] && !wd[`CTRL_REM_PROG];
      end else if (bad_commit || fatal_s) begin
        rem_run_reg <= 1'b0;
      end
      if (wr_ctrl) edit_reg <= wd[`CTRL_EDIT] && !wd[`CTRL_COMMIT] && run_reg;
    end
  end
  // Fatal latch: set wins; cleared by the program switch position or a remote program command in remote
  always_ff @(posedge aclk) begin
    if (!aresetn) fatal_reg <= 1'b0;
    else if (fatal_s || bad_commit) fatal_reg <= 1'b1;
    else if (sw_prog || (rem_prog_cmd && sw_s == scan_pkg::SW_REMOTE)) fatal_reg <= 1'b0;
  end
  // Non-fatal errors only counted; mode untouched
  always_ff @(posedge aclk) begin
    if (!aresetn) nf_count_reg <= 8'h00;
    else if (nonfatal_s && nf_count_reg != 8'hFF) nf_count_reg <= nf_count_reg + 8'h01;
    else if (wr_ctrl && wd[`CTRL_NF_CLR]) nf_count_reg <= 8'h00;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) run_reg <= 1'b0;
    else run_reg <= want_run && !fatal_reg && !fatal_s;
  end
  assign run_mode = run_reg;

  // ----------------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------------
  logic [18:0] rung;
  logic src_bit, rung_val;
  logic [31:0] dst_old, dst_new;
  assign rung = rung_mem[idx_reg];
  // Immediate rungs bypass the image and read the pin
  assign src_bit = rung[`RUNG_IMM] ? in_s[rung[7:3]] : img_mem[rung[2:0]][rung[7:3]];
  assign rung_val = src_bit ^ rung[`RUNG_INV];
  assign dst_old = img_mem[rung[12:10]];
  always_comb begin
    dst_new = dst_old;
    dst_new[rung[17:13]] = rung_val;
  end
  // Update honours the override mask; forces do not pass through it
  function automatic logic [31:0] keep(input logic [31:0] old, input logic [31:0] nw,
                                       input logic [31:0] m);
    return (old & m) | (nw & ~m);
  endfunction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seg_reg <= scan_pkg::ST_INIT;
      idx_reg <= 4'h0;
    end else begin
      case (seg_reg)
        scan_pkg::ST_INIT: begin
          idx_reg <= idx_reg + 4'h1;
          if (idx_reg == 4'h7) begin
            idx_reg <= 4'h0;
            seg_reg <= scan_pkg::ST_RD_IN;
          end
        end
        scan_pkg::ST_RD_IN: seg_reg <= scan_pkg::ST_RD_SPEC;
        scan_pkg::ST_RD_SPEC: seg_reg <= scan_pkg::ST_SERVICE;
        scan_pkg::ST_SERVICE: seg_reg <= scan_pkg::ST_BUS;
        scan_pkg::ST_BUS: seg_reg <= scan_pkg::ST_CLOCK;
        scan_pkg::ST_CLOCK: begin
          idx_reg <= 4'h0;
          seg_reg <= run_reg ? scan_pkg::ST_SOLVE : scan_pkg::ST_WR_OUT;
        end
        scan_pkg::ST_SOLVE: begin
          idx_reg <= idx_reg + 4'h1;
          if (rung[`RUNG_END] || idx_reg == 4'hF) begin
            idx_reg <= 4'h0;
            seg_reg <= scan_pkg::ST_LOOPS;
          end
        end
        scan_pkg::ST_LOOPS: begin
          // One cycle more than the configured loop count, always after the solve
          idx_reg <= idx_reg + 4'h1;
          if (idx_reg >= loops_reg) begin
            idx_reg <= 4'h0;
            seg_reg <= scan_pkg::ST_WR_OUT;
          end
        end
        scan_pkg::ST_WR_OUT: seg_reg <= scan_pkg::ST_RD_IN;
        default: seg_reg <= scan_pkg::ST_INIT;
      endcase
    end
  end
  // Image memory: one writer per segment
  always_ff @(posedge aclk) begin
    case (seg_reg)
      scan_pkg::ST_INIT: begin
        if (!retain_reg[idx_reg[2:0]]) img_mem[idx_reg[2:0]] <= 32'h0000_0000;
      end
      scan_pkg::ST_RD_IN: begin
        // Every mode reads inputs, program mode too
        img_mem[`IMG_X] <= keep(img_mem[`IMG_X], in_s, ovr_reg[`IMG_X]);
      end
      scan_pkg::ST_RD_SPEC: begin
        // Remote word is whatever the master holds now
        img_mem[`IMG_XR] <= keep(img_mem[`IMG_XR], {rem_s, spec_s}, ovr_reg[`IMG_XR]);
      end
      scan_pkg::ST_SERVICE: begin
        if (force_pend_reg) begin
          img_mem[force_reg[2:0]][force_reg[12:8]] <= force_reg[16];
        end
      end
      scan_pkg::ST_CLOCK: begin
        img_mem[`IMG_SP] <= {24'h00_0000, nf_count_reg != 8'h00, fatal_reg,
                             edit_reg, run_reg, sw_s, scan_cnt_reg == 32'h0, 1'b1};
      end
      scan_pkg::ST_SOLVE: begin
        if (!edit_reg) begin
          img_mem[rung[12:10]] <= keep(dst_old, dst_new, ovr_reg[rung[12:10]]);
        end
      end
      default: ;
    endcase
  end
  // Force requests wait for the service segment
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      force_reg <= 32'h0000_0000;
      force_pend_reg <= 1'b0;
    end else if (wr_force) begin
      force_reg <= wd;
      force_pend_reg <= 1'b1;
    end else if (seg_reg == scan_pkg::ST_SERVICE) begin
      force_pend_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Backplane transfers and clock values
  // ----------------------------------------------------------------------
  // Transfers only in the bus segment; requester waits otherwise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xfer_ack <= 1'b0;
      xfer_rdata <= 32'h0000_0000;
    end else begin
      xfer_ack <= xfer_req && seg_reg == scan_pkg::ST_BUS;
      if (xfer_req && seg_reg == scan_pkg::ST_BUS) xfer_rdata <= vmem[xfer_addr];
    end
  end
  // Word 0 holds the clock tick count and word 1 the scan count, refreshed in the clock segment
  always_ff @(posedge aclk) begin
    if (seg_reg == scan_pkg::ST_INIT && !retain_reg[`IMG_SP]) begin
      vmem[idx_reg[2:0]] <= 32'h0000_0000;
    end else if (seg_reg == scan_pkg::ST_BUS && xfer_req && xfer_write) begin
      vmem[xfer_addr] <= xfer_wdata;
    end else if (seg_reg == scan_pkg::ST_CLOCK) begin
      vmem[0] <= rtc_reg;
      vmem[1] <= scan_cnt_reg;
    end else if (wr_vmem) begin
      vmem[wa[4:2]] <= merge(vmem[wa[4:2]]);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_reg <= 32'h0000_0000;
      rtc_reg <= 32'h0000_0000;
    end else if (tick_reg == RTC_TICK_CYCLES - 1) begin
      tick_reg <= 32'h0000_0000;
      rtc_reg <= rtc_reg + 32'h1;
    end else begin
      tick_reg <= tick_reg + 32'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Scan time and outputs
  // ----------------------------------------------------------------------
  // Running average with weight 1/8; cheap, no divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_len_reg <= 32'h0000_0000;
      scan_avg_reg <= 32'h0000_0000;
      scan_cnt_reg <= 32'h0000_0000;
    end else if (seg_reg == scan_pkg::ST_WR_OUT) begin
      scan_len_reg <= 32'h0;
      scan_cnt_reg <= scan_cnt_reg + 32'h1;
      scan_avg_reg <= scan_cnt_reg == 32'h0 ? scan_len_reg + 32'h1
        : scan_avg_reg - (scan_avg_reg >> 3) + ((scan_len_reg + 32'h1) >> 3);
    end else if (seg_reg != scan_pkg::ST_INIT) begin
      scan_len_reg <= scan_len_reg + 32'h1;
    end
  end
  // Pins off outside run; held during an edit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_pins <= 32'h0000_0000;
      remote_out <= 32'h0000_0000;
    end else if (!run_reg || fatal_reg) begin
      out_pins <= 32'h0000_0000;
      remote_out <= 32'h0000_0000;
    end else if (seg_reg == scan_pkg::ST_WR_OUT && !edit_reg) begin
      out_pins <= img_mem[`IMG_Y];
      remote_out <= img_mem[`IMG_Y];
    end
  end
endmodule : scan_sequencer

// ==== testbench/scan_sequencer_chk.sv ====
// Concurrent checks on the scan sequencer ports.
// Assumes a single aclk domain with synchronous active-low reset.
`timescale 1ns/1ps
module scan_sequencer_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] mode_switch,
  input wire logic fatal_error,
  input wire logic xfer_req,
  input wire logic xfer_ack,
  input wire logic [31:0] out_pins,
  input wire logic [31:0] remote_out,
  input wire logic run_mode
);
  // One domain, so clock and disable are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
    out_pins == 32'h0 && !run_mode && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not quiet after reset");
  a_prog_dark: assert property (!run_mode [*8] |-> ##[0:40]
    out_pins == 32'h0 && remote_out == 32'h0) else $error("outputs driven out of run");
  a_fatal_stop: assert property (fatal_error |-> ##[1:40] !run_mode)
    else $error("fatal error left run mode on");
  a_fatal_dark: assert property (fatal_error [*2] |-> ##[1:48] out_pins == 32'h0)
    else $error("fatal error left outputs on");
  a_switch_prog: assert property (mode_switch == scan_pkg::SW_PROG [*8] |->
    ##[0:40] !run_mode) else $error("program switch did not stop run");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> s_axi_bvalid) else $error("write response late");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_xfer_cause: assert property (xfer_ack |-> $past(xfer_req))
    else $error("transfer ack without request");
  a_xfer_single: assert property (xfer_ack |=> !xfer_ack)
    else $error("transfer ack longer than one cycle");
endmodule : scan_sequencer_chk
bind scan_sequencer scan_sequencer_chk chk_i (.*);

// ==== testbench/spec_partner.sv ====
// Specialty module model that requests backplane transfers.
// Assumes requests are issued right after a rising aclk edge.
`timescale 1ns/1ps
module spec_partner (
  input wire logic aclk,
  input wire logic xfer_ack,
  input wire logic [31:0] xfer_rdata,
  output logic xfer_req = 1'b0,
  output logic xfer_write = 1'b0,
  output logic [2:0] xfer_addr = 3'h0,
  output logic [31:0] xfer_wdata = 32'h0
);
  // Request held whole until the ack edge; a hang returns unknown data
  task transfer(input logic w, input logic [2:0] a, input logic [31:0] d,
                output logic [31:0] rd);
    int n;
    n = 0;
    xfer_req <= 1'b1;
    xfer_write <= w;
    xfer_addr <= a;
    xfer_wdata <= d;
    do begin
      @(posedge aclk);
      n++;
    end while (xfer_ack !== 1'b1 && n < 500);
    rd = (n < 500) ? xfer_rdata : 'x;
    xfer_req <= 1'b0;
    xfer_wdata <= ~d; // Released data no longer shows the last value
  endtask : transfer
endmodule : spec_partner

// ==== testbench/tb_plc_scan_cycle_sequencer.sv ====
// Self-checking bench for the scan sequencer.
// Assumes the design header and package are compiled before it.
`timescale 1ns/1ps
`include "scan_params.svh"
module tb_plc_scan_cycle_sequencer;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [31:0] in_pins = 32'h0, xfer_wdata, s_axi_rdata, xfer_rdata, out_pins, remote_out;
  logic [15:0] specialty_in = 16'h0, remote_in = 16'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] xfer_addr;
  logic [1:0] mode_switch = 2'h0, s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, fatal_error = 1'b0, nonfatal_error = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic xfer_req, xfer_write, xfer_ack, run_mode;
  logic [31:0] rd, v;
  int mismatches = 0, checked = 0;
  // 100 MHz clock
  always #5 aclk = ~aclk;
  // Short clock tick so the clock segment has work in simulation
  scan_sequencer #(.RTC_TICK_CYCLES(10)) DUT (.*);
  spec_partner partner (.*);
  task tally_and_finish;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Handshake and poll waits pass through here, so a hang ends the run
  task step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 500) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : step
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do step(n); while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do step(n); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
  endtask : axi_wr
  task axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    do step(n); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do step(n); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask : axi_rd
  // Waits for run_mode (i < 0) or an output pin to reach a level
  task poll(input int i, input logic e);
    int n;
    n = 0;
    while ((i < 0 ? run_mode : out_pins[i]) !== e) step(n);
    chk({31'h0, (i < 0) ? run_mode : out_pins[i]}, {31'h0, e});
  endtask : poll
  task settle;
    repeat (40) @(posedge aclk);
  endtask : settle
  function logic [31:0] rung(input logic [2:0] sw, input logic [4:0] sb, input logic inv,
                             input logic imm, input logic [4:0] db, input logic last);
    return {13'h0, last, db, `IMG_Y, imm, inv, sb, sw};
  endfunction : rung
  // Main sequence; reset is held four cycles first
  initial begin
    void'($urandom(88001));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    chk(out_pins, 32'h0);
    axi_rd(`ADDR_RETAIN);
    chk(rd, {24'h0, `RETAIN_RESET});
    in_pins <= $urandom | 32'h1;
    specialty_in <= 16'($urandom);
    remote_in <= 16'($urandom);
    settle();
    axi_rd(`ADDR_IMG_BASE);
    chk(rd, in_pins);
    axi_rd(`ADDR_IMG_BASE + 8'h04);
    chk(rd, {remote_in, specialty_in});
    axi_rd(`ADDR_SCAN_AVG);
    chk(rd, 32'h6);
    axi_rd(`ADDR_IMG_BASE + 8'h1C);
    chk({28'h0, rd[4:2], rd[0]}, {28'h0, 1'b0, mode_switch, 1'b1});
    axi_rd(8'hF0);
    chk({30'h0, rs}, 32'h2);
    axi_wr(8'hF0, 32'h0);
    chk({30'h0, rs}, 32'h2);
    axi_wr(`ADDR_RUNG_BASE + 8'h04, rung(3'h0, 5'h0, 1'b0, 1'b0, 5'h0, 1'b1));
    mode_switch <= scan_pkg::SW_RUN;
    poll(-1, 1'b1);
    // Plain, inverted and immediate contacts; output flips every pass
    for (int k = 0; k < 5; k++) begin
      axi_wr(`ADDR_RUNG_BASE, rung(3'h0, 5'h0, k[0], k[1], 5'h5, 1'b0));
      poll(5, ~k[0]);
      chk({31'h0, remote_out[5]}, {31'h0, ~k[0]});
    end
    axi_wr(`ADDR_CTRL, 32'h1 << `CTRL_REM_PROG);
    settle();
    chk({31'h0, run_mode}, 32'h1);
    mode_switch <= scan_pkg::SW_REMOTE;
    settle();
    axi_wr(`ADDR_CTRL, 32'h1 << `CTRL_REM_RUN);
    poll(-1, 1'b1);
    axi_wr(`ADDR_CTRL, 32'h1 << `CTRL_REM_PROG);
    poll(-1, 1'b0);
    axi_wr(`ADDR_CTRL, 32'h1 << `CTRL_REM_RUN);
    poll(-1, 1'b1);
    nonfatal_error <= 1'b1;
    repeat (2) @(posedge aclk);
    nonfatal_error <= 1'b0;
    settle();
    axi_rd(`ADDR_STATUS);
    chk({rd[31:24], 23'h0, rd[0]}, {8'h2, 23'h0, 1'b1});
    // Every control write in remote restates the wanted mode
    axi_wr(`ADDR_CTRL, (32'h1 << `CTRL_NF_CLR) | (32'h1 << `CTRL_REM_RUN));
    axi_rd(`ADDR_STATUS);
    chk({rd[31:24], 23'h0, rd[0]}, {8'h0, 23'h0, 1'b1});
    // Override on X0, then a force that must stick under it
    axi_wr(`ADDR_OVR_BASE, 32'h1);
    in_pins[0] <= 1'b0;
    settle();
    chk({31'h0, out_pins[5]}, 32'h1);
    // Immediate contact sees the low pin that the image hides
    axi_wr(`ADDR_RUNG_BASE, rung(3'h0, 5'h0, 1'b0, 1'b1, 5'h5, 1'b0));
    poll(5, 1'b0);
    axi_wr(`ADDR_RUNG_BASE, rung(3'h0, 5'h0, 1'b0, 1'b0, 5'h5, 1'b0));
    poll(5, 1'b1);
    axi_wr(`ADDR_FORCE, 32'h0);
    poll(5, 1'b0);
    in_pins[0] <= 1'b1;
    settle();
    chk({31'h0, out_pins[5]}, 32'h0);
    axi_wr(`ADDR_OVR_BASE, 32'h0);
    poll(5, 1'b1);
    // Plain force is overwritten by the next input read
    axi_wr(`ADDR_FORCE, 32'h0);
    settle();
    axi_rd(`ADDR_IMG_BASE);
    chk(rd, in_pins);
    axi_wr(`ADDR_CTRL, (32'h1 << `CTRL_EDIT) | (32'h1 << `CTRL_REM_RUN));
    in_pins[0] <= 1'b0;
    settle();
    chk({31'h0, out_pins[5]}, 32'h1);
    axi_wr(`ADDR_CTRL, (32'h1 << `CTRL_COMMIT) | (32'h1 << `CTRL_BAD_PROG));
    poll(-1, 1'b0);
    settle();
    chk(out_pins, 32'h0);
    mode_switch <= scan_pkg::SW_PROG;
    in_pins[0] <= 1'b1;
    settle();
    mode_switch <= scan_pkg::SW_RUN;
    poll(5, 1'b1);
    fatal_error <= 1'b1;
    poll(-1, 1'b0);
    settle();
    chk(out_pins, 32'h0);
    fatal_error <= 1'b0;
    v = $urandom;
    partner.transfer(1'b1, 3'h3, v, rd);
    axi_rd(`ADDR_VMEM_BASE + 8'h0C);
    chk(rd, v);
    partner.transfer(1'b0, 3'h3, 32'h0, rd);
    chk(rd, v);
    // Forces into a retained and a cleared word, then a reset while the fatal latch holds run off
    axi_wr(`ADDR_FORCE, 32'h0001_0103);
    settle();
    axi_wr(`ADDR_FORCE, 32'h0001_0004);
    settle();
    axi_rd(`ADDR_IMG_BASE + 8'h10);
    chk(rd, 32'h1);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    axi_rd(`ADDR_IMG_BASE + 8'h0C);
    chk({31'h0, rd[1]}, 32'h1);
    axi_rd(`ADDR_IMG_BASE + 8'h10);
    chk(rd, 32'h0);
    tally_and_finish();
  end
endmodule : tb_plc_scan_cycle_sequencer
